/* File: verilog/dpc_pkg.sv */
// Shared constants and CRC step for the parameter-command link
package dpc_pkg;
    //--------------------------------------------------------------
    // Frame layout
    //--------------------------------------------------------------
    localparam int          FRAME_LEN    = 8;
    localparam int          BODY_LEN     = 6;
    localparam logic [7:0]  TYPE_SET     = 8'h06;
    localparam logic [7:0]  STATION_BCST = 8'hFF;
    localparam logic [7:0]  GROUP_SPECL  = 8'h00;
    localparam logic [7:0]  IDX_RUN      = 8'h02;
    localparam logic [7:0]  IDX_FREQ     = 8'h04;
    localparam int          RUN_FWD_BIT  = 0;
    localparam int          RUN_REV_BIT  = 1;
    localparam int          RUN_CLR_BIT  = 2;
    localparam int          FREQ_SCALE   = 100;
    localparam logic [15:0] FREQ_RST     = 16'h0000;
    //--------------------------------------------------------------
    // CRC
    //--------------------------------------------------------------
    localparam logic [15:0] CRC_PRESET   = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam int          CRC_STEPS    = 8;
    //--------------------------------------------------------------
    // Host command registers
    //--------------------------------------------------------------
    localparam logic [2:0]  HREG_STATION = 3'h0;
    localparam logic [2:0]  HREG_PARAM   = 3'h1;
    localparam logic [2:0]  HREG_DATA    = 3'h2;
    localparam logic [2:0]  HREG_CTRL    = 3'h3;
    localparam logic [2:0]  HREG_STATUS  = 3'h4;
    localparam logic [2:0]  HREG_RESP    = 3'h5;
    localparam int          ST_BUSY_BIT  = 0;
    localparam int          ST_DONE_BIT  = 1;
    localparam int          ST_CRCE_BIT  = 2;

    function automatic logic [15:0] dpc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < CRC_STEPS; i++) begin
            if (c[0]) begin
                c = (c >> 1) ^ CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : dpc_crc_byte
endpackage : dpc_pkg

/* File: verilog/dpc_link_if.sv */
// Byte stream link between controller and drive
`timescale 1ns/1ps
`default_nettype none
interface dpc_link_if;
    logic       h2d_valid;
    logic [7:0] h2d_data;
    logic       h2d_ready;
    logic       d2h_valid;
    logic [7:0] d2h_data;
    logic       d2h_ready;
    modport host (output h2d_valid, output h2d_data, input h2d_ready,
                  input d2h_valid, input d2h_data, output d2h_ready);
    modport dev  (input h2d_valid, input h2d_data, output h2d_ready,
                  output d2h_valid, output d2h_data, input d2h_ready);
endinterface : dpc_link_if
`default_nettype wire

/* File: verilog/dpc_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dpc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    always_comb begin
        wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = pop  ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; empty flag masks stale words
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule : dpc_fifo
`default_nettype wire

/* File: verilog/dpc_dev.sv */
// Drive end: decodes setting frames and answers good ones sent to its own station
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - CRC register starts at all ones
// - XOR each byte into CRC low half
// - Shift right, XOR polynomial on carry
// - Eight steps per byte, every byte
// - CRC sent low byte first, then high
// - CRC covers station through data bytes
// - Group 0, index 2 is run control
// - Bits: forward, reverse, fault clear
// - Group 0, index 4 sets frequency
// - Frequency word is hertz times hundred
// - Two-byte values travel high byte first
// - Refused write answers old stored value
// - Values are integers, decimal point dropped
// - Request: station, 0x06, address, data, CRC
// - Answer echoes station, type, address
module dpc_dev
    import dpc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    dpc_link_if.dev          link,
    input  wire logic [7:0]  station_i,
    input  wire logic        running_i,
    output logic             forward_run_request_o,
    output logic             reverse_run_request_o,
    output logic             fault_clear_o,
    output logic [15:0]      frequency_setpoint_o,
    output logic             frame_ok_o,
    output logic             crc_err_o
);
    typedef enum logic [1:0] {DS_RX, DS_EXEC, DS_TX} dpc_dstate_t;

    //--------------------------------------------------------------
    // Receive buffer
    //--------------------------------------------------------------
    logic       rx_valid, rx_ready;
    logic [7:0] rx_data;

    dpc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (link.h2d_valid),
        .in_data_i   (link.h2d_data),
        .in_ready_o  (link.h2d_ready),
        .out_valid_o (rx_valid),
        .out_data_o  (rx_data),
        .out_ready_i (rx_ready)
    );

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    dpc_dstate_t st_r, st_nxt;
    logic [7:0]  buf_r [BODY_LEN];
    logic [7:0]  buf_nxt [BODY_LEN];
    logic [2:0]  idx_r, idx_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic        crc_bad_r, crc_bad_nxt;
    logic        fwd_r, fwd_nxt, rev_r, rev_nxt, clr_r, clr_nxt;
    logic [15:0] freq_r, freq_nxt;
    logic        ok_r, ok_nxt, err_r, err_nxt;
    logic        txv_r, txv_nxt;
    logic [7:0]  txd_r, txd_nxt;
    logic        hs;

    assign rx_ready = (st_r == DS_RX);
    assign hs       = link.d2h_ready && txv_r;

    always_comb begin
        st_nxt      = st_r;
        buf_nxt     = buf_r;
        idx_nxt     = idx_r;
        crc_nxt     = crc_r;
        crc_bad_nxt = crc_bad_r;
        fwd_nxt     = fwd_r;
        rev_nxt     = rev_r;
        clr_nxt     = 1'b0;
        freq_nxt    = freq_r;
        ok_nxt      = 1'b0;
        err_nxt     = 1'b0;
        txv_nxt     = txv_r;
        txd_nxt     = txd_r;
        case (st_r)
            DS_RX: begin
                if (rx_valid) begin
                    if (idx_r < 3'(BODY_LEN)) begin
                        buf_nxt[idx_r] = rx_data;
                        crc_nxt = dpc_crc_byte(crc_r, rx_data);
                    end else if (idx_r == 3'(BODY_LEN)) begin
                        crc_bad_nxt = (rx_data != crc_r[7:0]);
                    end else begin
                        crc_bad_nxt = crc_bad_r || (rx_data != crc_r[15:8]);
                        st_nxt = DS_EXEC;
                    end
                    idx_nxt = idx_r + 3'h1;
                end
            end
            DS_EXEC: begin
                idx_nxt = '0;
                crc_nxt = CRC_PRESET;
                st_nxt  = DS_RX;
                if (crc_bad_r) begin
                    err_nxt = 1'b1;
                end else if ((buf_r[0] == station_i || buf_r[0] == STATION_BCST)
                             && buf_r[1] == TYPE_SET) begin
                    ok_nxt = 1'b1;
                    if (buf_r[2] == GROUP_SPECL && buf_r[3] == IDX_RUN) begin
                        fwd_nxt = buf_r[5][RUN_FWD_BIT];
                        rev_nxt = buf_r[5][RUN_REV_BIT];
                        clr_nxt = buf_r[5][RUN_CLR_BIT];
                    end else if (buf_r[2] == GROUP_SPECL && buf_r[3] == IDX_FREQ) begin
                        if (running_i) begin
                            buf_nxt[4] = freq_r[15:8];
                            buf_nxt[5] = freq_r[7:0];
                        end else begin
                            freq_nxt = {buf_r[4], buf_r[5]};
                        end
                    end
                    // Broadcast frames get no answer, avoiding bus collisions
                    if (buf_r[0] != STATION_BCST) begin
                        st_nxt  = DS_TX;
                        txv_nxt = 1'b1;
                        txd_nxt = buf_r[0];
                        crc_nxt = dpc_crc_byte(CRC_PRESET, buf_r[0]);
                    end
                end
            end
            DS_TX: begin
                if (hs) begin
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r == 3'(FRAME_LEN - 1)) begin
                        txv_nxt = 1'b0;
                        idx_nxt = '0;
                        crc_nxt = CRC_PRESET;
                        st_nxt  = DS_RX;
                    end else if (idx_r < 3'(BODY_LEN - 1)) begin
                        txd_nxt = buf_r[idx_r + 3'h1];
                        crc_nxt = dpc_crc_byte(crc_r, buf_r[idx_r + 3'h1]);
                    end else if (idx_r == 3'(BODY_LEN - 1)) begin
                        txd_nxt = crc_r[7:0];
                    end else begin
                        txd_nxt = crc_r[15:8];
                    end
                end
            end
            default: begin
                st_nxt = DS_RX;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r      <= DS_RX;
            for (int i = 0; i < BODY_LEN; i++) begin
                buf_r[i] <= 8'h00;
            end
            idx_r     <= '0;
            crc_r     <= CRC_PRESET;
            crc_bad_r <= 1'b0;
            fwd_r     <= 1'b0;
            rev_r     <= 1'b0;
            clr_r     <= 1'b0;
            freq_r    <= FREQ_RST;
            ok_r      <= 1'b0;
            err_r     <= 1'b0;
            txv_r     <= 1'b0;
            txd_r     <= 8'h00;
        end else begin
            st_r      <= st_nxt;
            buf_r     <= buf_nxt;
            idx_r     <= idx_nxt;
            crc_r     <= crc_nxt;
            crc_bad_r <= crc_bad_nxt;
            fwd_r     <= fwd_nxt;
            rev_r     <= rev_nxt;
            clr_r     <= clr_nxt;
            freq_r    <= freq_nxt;
            ok_r      <= ok_nxt;
            err_r     <= err_nxt;
            txv_r     <= txv_nxt;
            txd_r     <= txd_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign link.d2h_valid        = txv_r;
    assign link.d2h_data         = txd_r;
    assign forward_run_request_o = fwd_r;
    assign reverse_run_request_o = rev_r;
    assign fault_clear_o         = clr_r;
    assign frequency_setpoint_o  = freq_r;
    assign frame_ok_o            = ok_r;
    assign crc_err_o             = err_r;
endmodule : dpc_dev
`default_nettype wire

/* File: verilog/dpc_host.sv */
// Controller end: sends one setting frame, checks the answer
`timescale 1ns/1ps
`default_nettype none
module dpc_host
    import dpc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    dpc_link_if.host         link,
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [15:0]      rdata_o
);
    typedef enum logic [1:0] {HS_IDLE, HS_TX, HS_RX} dpc_hstate_t;

    dpc_hstate_t st_r, st_nxt;
    logic [7:0]  stn_r, stn_nxt;
    logic [15:0] par_r, par_nxt, dat_r, dat_nxt, resp_r, resp_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic [2:0]  idx_r, idx_nxt;
    logic        done_r, done_nxt, cerr_r, cerr_nxt;
    logic        txv_r, txv_nxt;
    logic [7:0]  txd_r, txd_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic [7:0]  body [BODY_LEN];

    // Frame body in send order, data high byte first
    assign body[0] = stn_r;
    assign body[1] = TYPE_SET;
    assign body[2] = par_r[15:8];
    assign body[3] = par_r[7:0];
    assign body[4] = dat_r[15:8];
    assign body[5] = dat_r[7:0];

    always_comb begin
        st_nxt   = st_r;
        stn_nxt  = stn_r;
        par_nxt  = par_r;
        dat_nxt  = dat_r;
        resp_nxt = resp_r;
        crc_nxt  = crc_r;
        idx_nxt  = idx_r;
        done_nxt = done_r;
        cerr_nxt = cerr_r;
        txv_nxt  = txv_r;
        txd_nxt  = txd_r;
        rd_nxt   = 16'h0000;
        if (we_i && st_r == HS_IDLE) begin
            // Writes during a transfer are dropped to keep the frame coherent
            case (addr_i)
                HREG_STATION: stn_nxt = wdata_i[7:0];
                HREG_PARAM:   par_nxt = wdata_i;
                HREG_DATA:    dat_nxt = wdata_i;
                HREG_CTRL: begin
                    if (wdata_i[0]) begin
                        st_nxt   = HS_TX;
                        done_nxt = 1'b0;
                        cerr_nxt = 1'b0;
                        idx_nxt  = '0;
                        txv_nxt  = 1'b1;
                        txd_nxt  = stn_r;
                        crc_nxt  = dpc_crc_byte(CRC_PRESET, stn_r);
                    end
                end
                default: begin
                end
            endcase
        end
        if (re_i) begin
            case (addr_i)
                HREG_STATION: rd_nxt = {8'h00, stn_r};
                HREG_PARAM:   rd_nxt = par_r;
                HREG_DATA:    rd_nxt = dat_r;
                HREG_STATUS:  rd_nxt = {13'h0000, cerr_r, done_r, st_r != HS_IDLE};
                HREG_RESP:    rd_nxt = resp_r;
                default:      rd_nxt = 16'h0000;
            endcase
        end
        case (st_r)
            HS_IDLE: begin
            end
            HS_TX: begin
                if (link.h2d_ready) begin
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r == 3'(FRAME_LEN - 1)) begin
                        txv_nxt = 1'b0;
                        idx_nxt = '0;
                        crc_nxt = CRC_PRESET;
                        // No answer comes back to a broadcast
                        if (stn_r == STATION_BCST) begin
                            st_nxt   = HS_IDLE;
                            done_nxt = 1'b1;
                        end else begin
                            st_nxt = HS_RX;
                        end
                    end else if (idx_r < 3'(BODY_LEN - 1)) begin
                        txd_nxt = body[idx_r + 3'h1];
                        crc_nxt = dpc_crc_byte(crc_r, body[idx_r + 3'h1]);
                    end else if (idx_r == 3'(BODY_LEN - 1)) begin
                        txd_nxt = crc_r[7:0];
                    end else begin
                        txd_nxt = crc_r[15:8];
                    end
                end
            end
            HS_RX: begin
                if (link.d2h_valid) begin
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r < 3'(BODY_LEN)) begin
                        crc_nxt = dpc_crc_byte(crc_r, link.d2h_data);
                        if (idx_r == 3'h4) begin
                            resp_nxt[15:8] = link.d2h_data;
                        end
                        if (idx_r == 3'h5) begin
                            resp_nxt[7:0] = link.d2h_data;
                        end
                    end else if (idx_r == 3'(BODY_LEN)) begin
                        cerr_nxt = (link.d2h_data != crc_r[7:0]);
                    end else begin
                        cerr_nxt = cerr_r || (link.d2h_data != crc_r[15:8]);
                        done_nxt = 1'b1;
                        st_nxt   = HS_IDLE;
                        idx_nxt  = '0;
                    end
                end
            end
            default: begin
                st_nxt = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= HS_IDLE;
            stn_r  <= 8'h00;
            par_r  <= 16'h0000;
            dat_r  <= 16'h0000;
            resp_r <= 16'h0000;
            crc_r  <= CRC_PRESET;
            idx_r  <= '0;
            done_r <= 1'b0;
            cerr_r <= 1'b0;
            txv_r  <= 1'b0;
            txd_r  <= 8'h00;
            rd_r   <= 16'h0000;
        end else begin
            st_r   <= st_nxt;
            stn_r  <= stn_nxt;
            par_r  <= par_nxt;
            dat_r  <= dat_nxt;
            resp_r <= resp_nxt;
            crc_r  <= crc_nxt;
            idx_r  <= idx_nxt;
            done_r <= done_nxt;
            cerr_r <= cerr_nxt;
            txv_r  <= txv_nxt;
            txd_r  <= txd_nxt;
            rd_r   <= rd_nxt;
        end
    end

    assign link.h2d_valid = txv_r;
    assign link.h2d_data  = txd_r;
    assign link.d2h_ready = (st_r == HS_RX);
    assign rdata_o        = rd_r;
endmodule : dpc_host
`default_nettype wire

/* File: tb/dpc_link_monitor.sv */
// Concurrent checks on the controller-to-drive byte link
`timescale 1ns/1ps
`default_nettype none
module dpc_link_monitor (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       h2d_valid,
    input wire logic [7:0] h2d_data,
    input wire logic       h2d_ready,
    input wire logic       d2h_valid,
    input wire logic [7:0] d2h_data,
    input wire logic       d2h_ready
);
    logic [2:0]  hx_r;
    logic [2:0]  dx_r;
    logic [15:0] hc_r;
    logic [15:0] dc_r;
    logic [7:0]  eb_r [4];
    wire logic   h_tk = h2d_valid & h2d_ready;
    wire logic   d_tk = d2h_valid & d2h_ready;

    function automatic logic [15:0] cstep(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
        end
        return r;
    endfunction : cstep

    // ------------------------------------------------------------
    // Frame position and running CRC, one set per direction
    // ------------------------------------------------------------
    // Byte counters wrap at eight; no resync, same as both ends
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hx_r <= 3'h0;
            dx_r <= 3'h0;
            hc_r <= 16'hFFFF;
            dc_r <= 16'hFFFF;
        end else begin
            if (h_tk) begin
                hx_r <= hx_r + 3'h1;
                if (hx_r < 3'h6) hc_r <= cstep((hx_r == 3'h0) ? 16'hFFFF : hc_r, h2d_data);
                if (hx_r < 3'h4) eb_r[hx_r[1:0]] <= h2d_data;
            end
            if (d_tk) begin
                dx_r <= dx_r + 3'h1;
                if (dx_r < 3'h6) dc_r <= cstep((dx_r == 3'h0) ? 16'hFFFF : dc_r, d2h_data);
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_h2d_hold_req: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
        else $error("request byte changed before taken");
    a_d2h_hold_ans: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
        else $error("answer byte changed before taken");
    a_h2d_type_set: assert property (h_tk && hx_r == 3'h1 |-> h2d_data == 8'h06)
        else $error("request frame type wrong");
    a_h2d_crc_low: assert property (h_tk && hx_r == 3'h6 |-> h2d_data == hc_r[7:0])
        else $error("request first check byte wrong");
    a_h2d_crc_high: assert property (h_tk && hx_r == 3'h7 |-> h2d_data == hc_r[15:8])
        else $error("request second check byte wrong");
    a_d2h_crc_low: assert property (d_tk && dx_r == 3'h6 |-> d2h_data == dc_r[7:0])
        else $error("answer first check byte wrong");
    a_d2h_crc_high: assert property (d_tk && dx_r == 3'h7 |-> d2h_data == dc_r[15:8])
        else $error("answer second check byte wrong");
    a_d2h_echo_head: assert property (d_tk && dx_r < 3'h4 |-> d2h_data == eb_r[dx_r[1:0]])
        else $error("answer header does not echo request");
endmodule : dpc_link_monitor
`default_nettype wire

/* File: tb/drive_param_command_crc_tb.sv */
// Self-checking bench: controller and drive ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module drive_param_command_crc_tb;
    import dpc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [2:0]  addr_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        we_i = 1'b0;
    logic        re_i = 1'b0;
    logic [15:0] rdata_o;
    logic [7:0]  station_i = 8'h05;
    logic        running_i = 1'b0;
    logic        forward_run_request_o, reverse_run_request_o, fault_clear_o;
    logic        frame_ok_o, crc_err_o;
    logic [15:0] frequency_setpoint_o;
    int          err_total = 0;
    int          checks = 0;
    int          clr_cnt = 0;
    int          ok_cnt = 0;
    int          crc_cnt = 0;
    int          c0;
    logic [15:0] seed = 16'h0043;
    logic [15:0] v;
    logic [15:0] old;
    logic [15:0] pa_frq;

    dpc_link_if link ();
    always #2.5 clk_i = ~clk_i;

    dpc_host dpc_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o));
    dpc_dev #(.FIFO_DEPTH(8)) dpc_dev_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
        .station_i(station_i), .running_i(running_i),
        .forward_run_request_o(forward_run_request_o),
        .reverse_run_request_o(reverse_run_request_o), .fault_clear_o(fault_clear_o),
        .frequency_setpoint_o(frequency_setpoint_o), .frame_ok_o(frame_ok_o),
        .crc_err_o(crc_err_o));
    dpc_link_monitor dpc_link_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready),
        .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready));

    // Pulses last one cycle, so they are counted at every edge
    always @(posedge clk_i) begin
        if (fault_clear_o === 1'b1) clr_cnt++;
        if (frame_ok_o === 1'b1) ok_cnt++;
        if (crc_err_o === 1'b1) crc_cnt++;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [15:0] exp_freq(input int hz);
        return 16'(hz * 100);
    endfunction : exp_freq

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // Broadcast sets done before the drive acts, hence the wait on frame_ok
    task automatic send(input logic [7:0] st, input logic [15:0] pa, input logic [15:0] d);
        int ok0;
        ok0 = ok_cnt;
        wr(HREG_STATION, {8'h00, st});
        wr(HREG_PARAM, pa);
        wr(HREG_DATA, d);
        wr(HREG_CTRL, 16'h0001);
        for (int i = 0; i < 60; i++) begin
            rd(HREG_STATUS, v);
            if (v[ST_DONE_BIT] === 1'b1) break;
        end
        for (int i = 0; i < 60 && ok_cnt == ok0; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        #1;
    endtask : send

    task automatic stop_test;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        stop_test;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        pa_frq = {GROUP_SPECL, IDX_FREQ};
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(HREG_STATUS, v);
        chk(v, 16'h0000);
        chk(frequency_setpoint_o, 16'h0000);
        rd(3'h6, v);
        chk(v, 16'h0000);
        rd(HREG_CTRL, v);
        chk(v, 16'h0000);
        $display("test reset_values done");
        send(8'h05, pa_frq, exp_freq(60));
        chk(frequency_setpoint_o, 16'h1770);
        rd(HREG_RESP, v);
        chk(v, 16'h1770);
        rd(HREG_STATUS, v);
        chk(v, 16'h0002);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            send(8'h05, pa_frq, seed);
            chk(frequency_setpoint_o, seed);
            rd(HREG_RESP, v);
            chk(v, seed);
        end
        $display("test frequency_writes done");
        @(posedge clk_i);
        running_i <= 1'b1;
        old = frequency_setpoint_o;
        seed = lfsr(seed);
        send(8'h05, pa_frq, seed);
        chk(frequency_setpoint_o, old);
        rd(HREG_RESP, v);
        chk(v, old);
        @(posedge clk_i);
        running_i <= 1'b0;
        $display("test refused_while_running done");
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            c0 = clr_cnt;
            send(8'h05, {GROUP_SPECL, IDX_RUN}, {seed[15:3], 3'(k)});
            chk({14'h0, reverse_run_request_o, forward_run_request_o}, 16'(k % 4));
            chk(16'(clr_cnt - c0), 16'(k / 4));
        end
        $display("test run_commands done");
        send(STATION_BCST, pa_frq, exp_freq(25));
        chk(frequency_setpoint_o, 16'h09C4);
        $display("test broadcast done");
        // Ordinary parameters are echoed but never stored
        seed = lfsr(seed);
        c0 = ok_cnt;
        send(8'h05, {8'h01, seed[7:0]}, seed);
        chk(frequency_setpoint_o, 16'h09C4);
        chk(16'(ok_cnt - c0), 16'h0001);
        rd(HREG_RESP, v);
        chk(v, seed);
        rd(HREG_PARAM, v);
        chk(v, {8'h01, seed[7:0]});
        $display("test other_parameter done");
        c0 = ok_cnt;
        send(8'h06, pa_frq, 16'h1234);
        chk(frequency_setpoint_o, 16'h09C4);
        chk(16'(ok_cnt - c0), 16'h0000);
        rd(HREG_STATUS, v);
        chk(v, 16'h0001);
        $display("test other_station done");
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1 chk(frequency_setpoint_o, 16'h0000);
        send(8'h05, pa_frq, exp_freq(1));
        chk(frequency_setpoint_o, 16'h0064);
        chk(16'(crc_cnt), 16'h0000);
        $display("test reset_recovery done");
        stop_test;
    end
endmodule : drive_param_command_crc_tb
`default_nettype wire
